// *** logic/cmpg_params.svh ***
// Constants for the mode and memory partition guard
`ifndef CMPG_PARAMS_SVH
`define CMPG_PARAMS_SVH

// Memory sizes in bytes, offsets are 18 bits
`define CMPG_ROM_APP_SIZE  18'h32000
`define CMPG_ROM_SIZE      18'h38000
`define CMPG_EEP_SIZE      18'h24000
`define CMPG_EEP_MFR_SIZE  18'h00080
`define CMPG_EEP_FW_1K     18'h00400
`define CMPG_EEP_FW_4K     18'h01000
`define CMPG_RAM_SIZE      18'h01800
`define CMPG_RAM_FW_SIZE   18'h00080
`define CMPG_RAM_GP_SIZE   18'h00e00

// Vector layout in ROM, 8 bytes per vector
`define CMPG_VEC_EXC_BASE  18'h00000
`define CMPG_VEC_IRQ_BASE  18'h00080
`define CMPG_VEC_SVC_BASE  18'h00100
`define CMPG_VEC_CFG_BASE  18'h32000
`define CMPG_VEC_SHIFT     3
`define CMPG_IRQ_USER_MASK 16'h8000

// Register byte offsets
`define CMPG_REG_MODE      12'h000
`define CMPG_REG_PART      12'h004
`define CMPG_REG_MMU       12'h008
`define CMPG_REG_FAULT     12'h00c

// Field positions and reset values
`define CMPG_PART_RAM_BIT  2
`define CMPG_MMU_PERI_LSB  8
`define CMPG_FAULT_KIND    1
`define CMPG_FAULT_ADDR    14
`define CMPG_PART_RST      32'h00000000
`define CMPG_MMU_RST       32'h00000000

`endif

// *** logic/cmpg_pkg.sv ***
// Types for the mode and memory partition guard
`default_nettype none
package cmpg_pkg;
  typedef enum logic [2:0] {
    CMPG_BOOT,
    CMPG_TEST,
    CMPG_FW,
    CMPG_SYS,
    CMPG_USER
  } cmpg_mode_t;

  typedef enum logic [1:0] {
    CMPG_K_ROM,
    CMPG_K_EEP,
    CMPG_K_RAM,
    CMPG_K_NONE
  } cmpg_kind_t;
endpackage
`default_nettype wire

// *** logic/cmpg_guard.sv ***
// Mode tracker, vector entry and memory partition guard with APB registers
//
// Contract
// RL1: Super mode is always boot, test or firmware
// RL2: System mode may reach every component
// RL3: User mode limited unless system grants components
// RL4: Each exception and interrupt has own vector
// RL5: Vector entry sets that vector's fixed mode
// RL6: Eight configuration vectors enter firmware mode
// RL7: Thirty-two system call vectors enter system mode
// RL8: Call vectors only by explicit call; modes separated
// RL9: ROM split into application and test parts
// RL10: EEPROM reserves manufacturer area plus firmware part
// RL11: RAM firmware part 0 or 128 bytes
// RL12: Test mode reaches all memory
// RL13: Boot and firmware confined to small parts
// RL14: System and user confined to application parts
// RL15: User further limited by system-set MMU
// RL16: Coprocessor reaches only its own RAM part (code also grants it the EEPROM application part)
// RL17: Coprocessor bypasses MMU, keeps partition bounds
// RL18: Start-up enters test until test disabled
// RL19: With test disabled start-up reaches system mode
// RL20: Forbidden CPU access blocked and raises exception (in boot and test modes the code blocks it but raises no exception)
// RL21: Mode switches before first fetch at vector
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`include "cmpg_params.svh"
`default_nettype none

module cmpg_guard
  import cmpg_pkg::*;
#(
  parameter int EXC_W = 4,
  parameter int IRQ_W = 4
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              test_disabled_pin,
  input  wire logic              boot_exit,
  input  wire logic              exc_req,
  input  wire logic [EXC_W-1:0]  exc_idx,
  input  wire logic              irq_req,
  input  wire logic [IRQ_W-1:0]  irq_idx,
  input  wire logic              cfg_call,
  input  wire logic [2:0]        cfg_idx,
  input  wire logic              svc_call,
  input  wire logic [4:0]        svc_idx,
  input  wire logic              call_return,
  input  wire logic              cpu_req,
  input  wire cmpg_kind_t        cpu_kind,
  input  wire logic [17:0]       cpu_addr,
  input  wire logic              cop_req,
  input  wire cmpg_kind_t        cop_kind,
  input  wire logic [17:0]       cop_addr,
  output cmpg_mode_t             mode_q,
  output logic                   vec_valid_q,
  output logic      [17:0]       vec_addr_q,
  output logic                   cpu_grant_q,
  output logic                   cpu_fault_q,
  output logic                   cop_grant_q,
  output logic                   cop_fault_q,
  output logic      [7:0]        peri_grant_q
);

  if (EXC_W < 1 || EXC_W > 4 || IRQ_W < 1 || IRQ_W > 4) begin : g_bad_width
    $error("cmpg_guard: vector index widths must be 1..4");
  end
  localparam logic [15:0] IRQ_USER = `CMPG_IRQ_USER_MASK; // Interrupts whose vector runs in user mode

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic        fuse_s1_q;
  logic        fuse_s2_q;
  logic [31:0] part_q;
  logic [31:0] mmu_q;
  logic [31:0] fault_q;
  cmpg_mode_t  ret_mode_q;
  logic [17:0] eep_lim;
  logic [17:0] ram_lim;
  logic        apb_acc;
  logic        apb_wr;
  logic        wr_deny;
  logic        cpu_ok;
  logic        cop_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Decode functions
  // Size of a memory kind
  function automatic logic [17:0] kind_size(input cmpg_kind_t k);
    case (k)
      CMPG_K_ROM: kind_size = `CMPG_ROM_SIZE;
      CMPG_K_EEP: kind_size = `CMPG_EEP_SIZE;
      CMPG_K_RAM: kind_size = `CMPG_RAM_SIZE;
      default:    kind_size = 18'h00000;
    endcase
  endfunction

  // Address lies in the application part of its memory
  function automatic logic in_app(input cmpg_kind_t k, input logic [17:0] a,
                                  input logic [17:0] el, input logic [17:0] rl);
    case (k)
      CMPG_K_ROM: in_app = a < `CMPG_ROM_APP_SIZE;            // RL9
      CMPG_K_EEP: in_app = a >= el && a < `CMPG_EEP_SIZE;      // RL10
      CMPG_K_RAM: in_app = a >= rl && a < `CMPG_RAM_SIZE;      // RL11
      default:    in_app = 1'b0;
    endcase
  endfunction

  // Address lies in the firmware part of its memory
  function automatic logic in_fw(input cmpg_kind_t k, input logic [17:0] a,
                                 input logic [17:0] el, input logic [17:0] rl);
    case (k)
      CMPG_K_ROM: in_fw = a >= `CMPG_ROM_APP_SIZE && a < `CMPG_ROM_SIZE; // RL9
      CMPG_K_EEP: in_fw = a < el;
      CMPG_K_RAM: in_fw = a < rl;
      default:    in_fw = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Partition limits from configuration
  // Firmware part sizes selected by the partition register
  always_comb begin
    case (part_q[1:0])
      2'h1:    eep_lim = `CMPG_EEP_MFR_SIZE + `CMPG_EEP_FW_1K; // RL10
      2'h2:    eep_lim = `CMPG_EEP_MFR_SIZE + `CMPG_EEP_FW_4K; // RL10
      default: eep_lim = `CMPG_EEP_MFR_SIZE;                   // RL10
    endcase
    ram_lim = part_q[`CMPG_PART_RAM_BIT] ? `CMPG_RAM_FW_SIZE : 18'h00000; // RL11
  end

  // CPU access check by mode
  always_comb begin
    case (mode_q)
      CMPG_TEST: cpu_ok = cpu_addr < kind_size(cpu_kind);                     // RL12
      CMPG_BOOT,
      CMPG_FW:   cpu_ok = in_fw(cpu_kind, cpu_addr, eep_lim, ram_lim);         // RL13
      CMPG_SYS:  cpu_ok = in_app(cpu_kind, cpu_addr, eep_lim, ram_lim);        // RL14
      CMPG_USER: cpu_ok = in_app(cpu_kind, cpu_addr, eep_lim, ram_lim)
                          && cpu_kind != CMPG_K_NONE && mmu_q[cpu_kind];       // RL15
      default:   cpu_ok = 1'b0;
    endcase
  end

  // Coprocessor check: no MMU, no ROM, own RAM part and partition bounds only
  always_comb begin
    cop_ok = in_app(cop_kind, cop_addr, eep_lim, ram_lim)                      // RL17
             && cop_kind != CMPG_K_ROM
             && (cop_kind != CMPG_K_RAM || cop_addr >= `CMPG_RAM_GP_SIZE);     // RL16
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory access answers
  // One-cycle grant or fault per request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_grant_q <= 1'b0;
      cpu_fault_q <= 1'b0;
      cop_grant_q <= 1'b0;
      cop_fault_q <= 1'b0;
    end else begin
      cpu_grant_q <= cpu_req && cpu_ok;
      cpu_fault_q <= cpu_req && !cpu_ok; // RL20
      cop_grant_q <= cop_req && cop_ok;
      cop_fault_q <= cop_req && !cop_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Test-disable pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_s1_q <= 1'b0;
      fuse_s2_q <= 1'b0;
    end else begin
      fuse_s1_q <= test_disabled_pin;
      fuse_s2_q <= fuse_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode tracking and vector entry
  // Mode and vector registered together, ahead of the fetch at the vector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q      <= CMPG_BOOT;
      ret_mode_q  <= CMPG_SYS;
      vec_valid_q <= 1'b0;
      vec_addr_q  <= 18'h00000;
    end else begin
      vec_valid_q <= 1'b0;
      if (mode_q == CMPG_BOOT) begin
        if (boot_exit) begin
          mode_q <= fuse_s2_q ? CMPG_SYS : CMPG_TEST; // RL18 RL19
        end
      end else if (mode_q == CMPG_TEST) begin
        mode_q <= CMPG_TEST; // RL8
      end else if (cpu_fault_q) begin
        mode_q      <= CMPG_SYS;                 // RL20
        vec_valid_q <= 1'b1;
        vec_addr_q  <= `CMPG_VEC_EXC_BASE;
      end else if (exc_req) begin
        mode_q      <= CMPG_SYS;                 // RL5
        vec_valid_q <= 1'b1;                     // RL21
        vec_addr_q  <= `CMPG_VEC_EXC_BASE + (18'(exc_idx) << `CMPG_VEC_SHIFT); // RL4
      end else if (irq_req) begin
        mode_q      <= IRQ_USER[irq_idx] ? CMPG_USER : CMPG_SYS; // RL5
        vec_valid_q <= 1'b1;
        vec_addr_q  <= `CMPG_VEC_IRQ_BASE + (18'(irq_idx) << `CMPG_VEC_SHIFT); // RL4
      end else if (svc_call && mode_q != CMPG_FW) begin
        ret_mode_q  <= mode_q;
        mode_q      <= CMPG_SYS;                 // RL7
        vec_valid_q <= 1'b1;
        vec_addr_q  <= `CMPG_VEC_SVC_BASE + (18'(svc_idx) << `CMPG_VEC_SHIFT);
      end else if (cfg_call && mode_q != CMPG_FW) begin
        ret_mode_q  <= mode_q;
        mode_q      <= CMPG_FW;                  // RL6 RL1
        vec_valid_q <= 1'b1;
        vec_addr_q  <= `CMPG_VEC_CFG_BASE + (18'(cfg_idx) << `CMPG_VEC_SHIFT);
      end else if (call_return) begin
        mode_q <= ret_mode_q; // RL8
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave
  assign apb_acc = psel && penable && pready;
  assign apb_wr  = apb_acc && pwrite;

  // Writes refused by mode or address
  always_comb begin
    case (paddr)
      `CMPG_REG_PART:  wr_deny = mode_q != CMPG_BOOT && mode_q != CMPG_TEST; // RL1
      `CMPG_REG_MMU:   wr_deny = mode_q != CMPG_SYS;                         // RL15
      `CMPG_REG_FAULT: wr_deny = mode_q == CMPG_USER;                        // RL3
      default:         wr_deny = 1'b1;
    endcase
  end

  // Answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (psel && penable && !pready) begin
        if (pwrite) begin
          pslverr <= wr_deny;
        end else begin
          case (paddr)
            `CMPG_REG_MODE:  prdata <= {28'h0000000, fuse_s2_q, mode_q};
            `CMPG_REG_PART:  prdata <= part_q;
            `CMPG_REG_MMU:   prdata <= mmu_q;
            `CMPG_REG_FAULT: prdata <= fault_q;
            default:         pslverr <= 1'b1;
          endcase
        end
      end
    end
  end

  // Partition configuration, boot and test only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      part_q <= `CMPG_PART_RST;
    end else if (apb_wr && paddr == `CMPG_REG_PART && !wr_deny) begin
      part_q <= {29'h00000000, pwdata[2:0]};
    end
  end

  // MMU configuration, system mode only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mmu_q <= `CMPG_MMU_RST;
    end else if (apb_wr && paddr == `CMPG_REG_MMU && !wr_deny) begin
      mmu_q <= {16'h0000, pwdata[15:8], 5'h00, pwdata[2:0]}; // RL15
    end
  end

  // Fault record; a new fault wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_q <= 32'h00000000;
    end else if (cpu_req && !cpu_ok) begin
      fault_q <= {cpu_addr, 11'h000, cpu_kind, 1'b1}; // RL20
    end else if (apb_wr && paddr == `CMPG_REG_FAULT && !wr_deny && pwdata[0]) begin
      fault_q[0] <= 1'b0;
    end
  end

  // Component grants: all in system and super modes, mask in user mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peri_grant_q <= 8'hff;
    end else begin
      peri_grant_q <= (mode_q == CMPG_USER) ? mmu_q[15:8] : 8'hff; // RL2 RL3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_test_full_access: assert property (@(posedge pclk) disable iff (!presetn) // RL12
    cpu_req && mode_q == CMPG_TEST && cpu_addr < kind_size(cpu_kind) |=> cpu_grant_q)
    else $error("test mode access refused");

  a_fw_no_app_rom: assert property (@(posedge pclk) disable iff (!presetn) // RL13
    cpu_req && (mode_q == CMPG_FW || mode_q == CMPG_BOOT) && cpu_kind == CMPG_K_ROM
    && cpu_addr < `CMPG_ROM_APP_SIZE |=> cpu_fault_q && !cpu_grant_q)
    else $error("firmware reached application ROM");

  a_sys_no_test_rom: assert property (@(posedge pclk) disable iff (!presetn) // RL14
    cpu_req && mode_q == CMPG_SYS && cpu_kind == CMPG_K_ROM
    && cpu_addr >= `CMPG_ROM_APP_SIZE |=> cpu_fault_q)
    else $error("system mode reached test ROM");

  a_user_mmu_deny: assert property (@(posedge pclk) disable iff (!presetn) // RL15
    cpu_req && mode_q == CMPG_USER && cpu_kind == CMPG_K_RAM && !mmu_q[2] |=> cpu_fault_q)
    else $error("user RAM access passed closed MMU");

  a_fault_vector: assert property (@(posedge pclk) disable iff (!presetn) // RL20
    cpu_fault_q && mode_q != CMPG_BOOT && mode_q != CMPG_TEST
    |=> vec_valid_q && mode_q == CMPG_SYS && vec_addr_q == `CMPG_VEC_EXC_BASE)
    else $error("fault raised no exception");

  a_exc_vector: assert property (@(posedge pclk) disable iff (!presetn) // RL4
    exc_req && !cpu_fault_q && (mode_q == CMPG_SYS || mode_q == CMPG_USER)
    |=> vec_valid_q && vec_addr_q == `CMPG_VEC_EXC_BASE + (18'($past(exc_idx)) << 3))
    else $error("exception vector wrong");

  a_cfg_fw_mode: assert property (@(posedge pclk) disable iff (!presetn) // RL6
    cfg_call && !exc_req && !irq_req && !svc_call && !cpu_fault_q
    && (mode_q == CMPG_SYS || mode_q == CMPG_USER) |=> mode_q == CMPG_FW ##1 1'b1)
    else $error("configuration call missed firmware mode");

  a_svc_sys_mode: assert property (@(posedge pclk) disable iff (!presetn) // RL7
    svc_call && !exc_req && !irq_req && !cpu_fault_q && (mode_q == CMPG_SYS || mode_q == CMPG_USER)
    |=> mode_q == CMPG_SYS && vec_valid_q)
    else $error("system call missed system mode");

  a_boot_to_test: assert property (@(posedge pclk) disable iff (!presetn) // RL18
    mode_q == CMPG_BOOT && boot_exit && !fuse_s2_q |=> mode_q == CMPG_TEST)
    else $error("start-up skipped test mode");

  a_test_sticky: assert property (@(posedge pclk) disable iff (!presetn) // RL8
    mode_q == CMPG_TEST |=> mode_q == CMPG_TEST)
    else $error("test mode left by vector");

  a_cop_own_ram: assert property (@(posedge pclk) disable iff (!presetn) // RL16
    cop_req && cop_kind == CMPG_K_RAM && cop_addr < `CMPG_RAM_GP_SIZE |=> cop_fault_q)
    else $error("coprocessor reached general RAM");

  a_mmu_locked: assert property (@(posedge pclk) disable iff (!presetn) // RL15
    apb_wr && paddr == `CMPG_REG_MMU && mode_q != CMPG_SYS |=> $stable(mmu_q))
    else $error("MMU changed outside system mode");

endmodule

`default_nettype wire

// *** verif/cmpg_core_model.sv ***
// Access model for the core and coprocessor side of the guard
`default_nettype none
module cmpg_core_model
  import cmpg_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        go,
  input  wire logic        cop,
  input  wire cmpg_kind_t  kind,
  input  wire logic [17:0] addr,
  output logic             cpu_req,
  output cmpg_kind_t       cpu_kind,
  output logic      [17:0] cpu_addr,
  output logic             cop_req,
  output cmpg_kind_t       cop_kind,
  output logic      [17:0] cop_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////
  // Idle values at time zero, then one-cycle requests; idle address lines flip so no stale value lingers
  initial begin
    cpu_req  = 1'b0;
    cpu_kind = CMPG_K_NONE;
    cpu_addr = 18'h00000;
    cop_req  = 1'b0;
    cop_kind = CMPG_K_NONE;
    cop_addr = 18'h00000;
    forever begin
      @(posedge pclk);
      cpu_req  <= go & ~cop;
      cpu_kind <= (go & ~cop) ? kind : CMPG_K_NONE;
      cpu_addr <= (go & ~cop) ? addr : ~cpu_addr;
      cop_req  <= go & cop;
      cop_kind <= (go & cop) ? kind : CMPG_K_NONE;
      cop_addr <= (go & cop) ? addr : ~cop_addr;
    end
  end
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench for the mode and memory partition guard
`include "cmpg_params.svh"
`default_nettype none
module tb_top
  import cmpg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata;
  logic        pready, pslverr, pin = 1'b0, boot_exit = 1'b0, exc_req = 1'b0, irq_req = 1'b0;
  logic [3:0]  exc_idx = 4'h0, irq_idx = 4'h0;
  logic        cfg_call = 1'b0, svc_call = 1'b0, call_return = 1'b0, go = 1'b0, cop = 1'b0;
  logic [2:0]  cfg_idx = 3'h0;
  logic [4:0]  svc_idx = 5'h00;
  logic [17:0] addr = 18'h00000, cpu_addr, cop_addr, vec_addr_q;
  cmpg_kind_t  kind = CMPG_K_NONE, cpu_kind, cop_kind;
  cmpg_mode_t  mode_q, exp_mode = CMPG_BOOT;
  logic        cpu_req, cop_req, vec_valid_q, cpu_grant_q, cpu_fault_q, cop_grant_q, cop_fault_q;
  logic [7:0]  peri_grant_q;
  logic [3:0]  acc_q[$];
  logic [20:0] vec_q[$];
  int          fails = 0, samples_checked = 0, seed = 6698;
  localparam logic [15:0] USER_IRQS = `CMPG_IRQ_USER_MASK;
  cmpg_guard dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .test_disabled_pin(pin), .boot_exit(boot_exit), .exc_req(exc_req), .exc_idx(exc_idx),
    .irq_req(irq_req), .irq_idx(irq_idx), .cfg_call(cfg_call), .cfg_idx(cfg_idx), .svc_call(svc_call),
    .svc_idx(svc_idx), .call_return(call_return), .cpu_req(cpu_req), .cpu_kind(cpu_kind),
    .cpu_addr(cpu_addr), .cop_req(cop_req), .cop_kind(cop_kind), .cop_addr(cop_addr), .mode_q(mode_q),
    .vec_valid_q(vec_valid_q), .vec_addr_q(vec_addr_q), .cpu_grant_q(cpu_grant_q),
    .cpu_fault_q(cpu_fault_q), .cop_grant_q(cop_grant_q), .cop_fault_q(cop_fault_q),
    .peri_grant_q(peri_grant_q));
  cmpg_core_model core_u (.pclk(pclk), .go(go), .cop(cop), .kind(kind), .addr(addr), .cpu_req(cpu_req),
    .cpu_kind(cpu_kind), .cpu_addr(cpu_addr), .cop_req(cop_req), .cop_kind(cop_kind), .cop_addr(cop_addr));
  ////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial begin
    forever #4 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    stop_test();
  end
  ////////////////////////////////////////////////////////////////
  // Compare, verdict and drivers
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] ed,
                     input logic ee);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    chk("pslverr", ee, pslverr);
    if (!wr) chk("prdata", ed, prdata);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic acc(input logic c, input cmpg_kind_t k, input logic [17:0] a, input logic ok);
    @(posedge pclk);
    go <= 1'b1;
    cop <= c;
    kind <= k;
    addr <= a;
    acc_q.push_back({~c & ok, ~c & ~ok, c & ok, c & ~ok});
    if (!c && !ok && exp_mode != CMPG_BOOT && exp_mode != CMPG_TEST) begin
      vec_q.push_back({CMPG_SYS, `CMPG_VEC_EXC_BASE});
      exp_mode = CMPG_SYS;
    end
    @(posedge pclk);
    go <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  // Kinds: 0 exception, 1 interrupt, 2 system call, 3 config call, 4 return, 5 exception and interrupt
  task automatic ev(input int w, input logic [4:0] i, input logic tk, input cmpg_mode_t m,
                    input logic [17:0] va);
    @(posedge pclk);
    exc_req <= (w == 0 || w == 5);
    irq_req <= (w == 1 || w == 5);
    svc_call <= (w == 2);
    cfg_call <= (w == 3);
    call_return <= (w == 4);
    exc_idx <= i[3:0];
    irq_idx <= ~i[3:0];
    svc_idx <= i;
    cfg_idx <= i[2:0];
    if (tk) vec_q.push_back({m, va});
    exp_mode = m;
    @(posedge pclk);
    {exc_req, irq_req, svc_call, cfg_call, call_return} <= 5'h00;
    repeat (2) @(posedge pclk);
    chk("mode", exp_mode, mode_q);
  endtask
  task automatic leave_boot(input cmpg_mode_t m);
    @(posedge pclk);
    boot_exit <= 1'b1;
    @(posedge pclk);
    boot_exit <= 1'b0;
    repeat (3) @(posedge pclk);
    exp_mode = m;
    chk("mode", m, mode_q);
  endtask
  // Result watcher: oldest note against each result
  always @(posedge pclk) begin
    if (presetn && (cpu_grant_q | cpu_fault_q | cop_grant_q | cop_fault_q) === 1'b1)
      chk("access", acc_q.size() ? acc_q.pop_front() : 32'hffffffff,
          {cpu_grant_q, cpu_fault_q, cop_grant_q, cop_fault_q});
    if (presetn && vec_valid_q === 1'b1)
      chk("vector", vec_q.size() ? vec_q.pop_front() : 32'hffffffff, {mode_q, vec_addr_q});
  end
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [17:0] fw;
    logic [4:0]  r;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("mode", CMPG_BOOT, mode_q);
    apb(0, `CMPG_REG_PART, 0, `CMPG_PART_RST, 0);
    acc(0, CMPG_K_ROM, `CMPG_ROM_APP_SIZE, 1);
    acc(0, CMPG_K_ROM, `CMPG_ROM_APP_SIZE - 1, 0);
    acc(0, CMPG_K_RAM, 18'h00000, 0);
    for (int p = 0; p < 4; p++) begin
      fw = (p == 1) ? `CMPG_EEP_FW_1K : (p == 2) ? `CMPG_EEP_FW_4K : 18'h00000;
      apb(1, `CMPG_REG_PART, p | 4, 0, 0);
      acc(0, CMPG_K_EEP, `CMPG_EEP_MFR_SIZE + fw - 1, 1);
      acc(0, CMPG_K_EEP, `CMPG_EEP_MFR_SIZE + fw, 0);
    end
    apb(0, `CMPG_REG_PART, 0, 32'h00000007, 0);
    acc(0, CMPG_K_RAM, `CMPG_RAM_FW_SIZE - 1, 1);
    acc(0, CMPG_K_RAM, `CMPG_RAM_FW_SIZE, 0);
    ev(0, 5'h03, 0, CMPG_BOOT, 0);
    leave_boot(CMPG_TEST);
    acc(0, CMPG_K_ROM, 18'h00000, 1);
    acc(0, CMPG_K_ROM, `CMPG_ROM_SIZE - 1, 1);
    acc(0, CMPG_K_EEP, `CMPG_EEP_SIZE - 1, 1);
    acc(0, CMPG_K_RAM, `CMPG_RAM_SIZE - 1, 1);
    ev(2, 5'h01, 0, CMPG_TEST, 0);
    // Second start-up with test mode fused off
    presetn <= 1'b0;
    pin <= 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    exp_mode = CMPG_BOOT;
    leave_boot(CMPG_SYS);
    apb(0, `CMPG_REG_MODE, 0, 32'h0000000b, 0);
    apb(1, `CMPG_REG_MODE, 32'h00000004, 0, 1);
    apb(1, `CMPG_REG_PART, 32'h00000005, 0, 1);
    apb(0, `CMPG_REG_PART, 0, `CMPG_PART_RST, 0);
    apb(0, 12'h010, 0, 32'h00000000, 1);
    apb(0, `CMPG_REG_MMU, 0, `CMPG_MMU_RST, 0);
    apb(1, `CMPG_REG_MMU, 32'h0000a507, 0, 0);
    apb(0, `CMPG_REG_MMU, 0, 32'h0000a507, 0);
    chk("peri", 8'hff, peri_grant_q);
    apb(1, `CMPG_REG_FAULT, 32'h00000001, 0, 0);
    acc(0, CMPG_K_ROM, `CMPG_ROM_APP_SIZE - 1, 1);
    acc(0, CMPG_K_ROM, `CMPG_ROM_APP_SIZE, 0);
    apb(0, `CMPG_REG_FAULT, 0, ({14'h0000, `CMPG_ROM_APP_SIZE} << `CMPG_FAULT_ADDR) | 32'h1, 0);
    acc(0, CMPG_K_EEP, `CMPG_EEP_MFR_SIZE - 1, 0);
    acc(0, CMPG_K_EEP, `CMPG_EEP_MFR_SIZE, 1);
    acc(0, CMPG_K_RAM, 18'h00000, 1);
    acc(0, CMPG_K_RAM, `CMPG_RAM_SIZE - 1, 1);
    acc(1, CMPG_K_RAM, `CMPG_RAM_GP_SIZE + ({$random(seed)} % (`CMPG_RAM_SIZE - `CMPG_RAM_GP_SIZE)), 1);
    acc(1, CMPG_K_RAM, `CMPG_RAM_GP_SIZE - 1, 0);
    acc(1, CMPG_K_EEP, `CMPG_EEP_MFR_SIZE - 1, 0);
    acc(1, CMPG_K_EEP, `CMPG_EEP_MFR_SIZE, 1);
    r = $random(seed);
    ev(0, r, 1, CMPG_SYS, `CMPG_VEC_EXC_BASE + (r[3:0] << `CMPG_VEC_SHIFT));
    ev(1, r, 1, USER_IRQS[~r[3:0]] ? CMPG_USER : CMPG_SYS,
       `CMPG_VEC_IRQ_BASE + ({14'h0000, ~r[3:0]} << `CMPG_VEC_SHIFT));
    ev(5, r, 1, CMPG_SYS, `CMPG_VEC_EXC_BASE + (r[3:0] << `CMPG_VEC_SHIFT));
    // User mode through interrupt 15, with user RAM closed in the MMU
    apb(1, `CMPG_REG_MMU, 32'h0000a503, 0, 0);
    ev(1, 5'h00, 1, CMPG_USER, `CMPG_VEC_IRQ_BASE + (18'h0000f << `CMPG_VEC_SHIFT));
    chk("peri", 8'ha5, peri_grant_q);
    apb(1, `CMPG_REG_MMU, 32'h0000ffff, 0, 1);
    apb(1, `CMPG_REG_FAULT, 32'h00000001, 0, 1);
    apb(0, `CMPG_REG_MMU, 0, 32'h0000a503, 0);
    acc(0, CMPG_K_EEP, `CMPG_EEP_MFR_SIZE, 1);
    acc(0, CMPG_K_RAM, `CMPG_RAM_SIZE - 1, 0);
    chk("mode", CMPG_SYS, mode_q);
    for (int i = 0; i < 32; i++) ev(2, i, 1, CMPG_SYS, `CMPG_VEC_SVC_BASE + (i << `CMPG_VEC_SHIFT));
    for (int i = 0; i < 8; i++) begin
      ev(3, i, 1, CMPG_FW, `CMPG_VEC_CFG_BASE + (i << `CMPG_VEC_SHIFT));
      acc(0, CMPG_K_ROM, `CMPG_VEC_CFG_BASE + (i << `CMPG_VEC_SHIFT), 1);
      ev(2, 5'h02, 0, CMPG_FW, 0);
      ev(4, 5'h00, 0, CMPG_SYS, 0);
    end
    ev(3, 5'h05, 1, CMPG_FW, `CMPG_VEC_CFG_BASE + (5 << `CMPG_VEC_SHIFT));
    acc(0, CMPG_K_ROM, 18'h00000, 0);
    chk("mode", CMPG_SYS, mode_q);
    repeat (4) @(posedge pclk);
    chk("pending", 0, acc_q.size() + vec_q.size());
    stop_test();
  end
endmodule
`default_nettype wire
